// *** include/ilr_pkg.sv ***
// shared constants and types for the io line reset and configuration block
package ilr_pkg;

    // line count and index width (port a lines 0..22, port b lines 23..35)
    localparam int NUM_LINES = 36;
    localparam int LINE_W = 6;

    // peripheral function codes a..h
    localparam int FN_W = 3;
    localparam logic [FN_W-1:0] FN_A = 3'h0;
    localparam logic [FN_W-1:0] FN_F = 3'h5;
    // function code used by the two-wire interface on its lines
    localparam logic [FN_W-1:0] FN_TWI = FN_A;

    // test port pins
    localparam logic [LINE_W-1:0] LINE_TCK = 6'h00;
    localparam logic [LINE_W-1:0] LINE_TMS = 6'h01;
    localparam logic [LINE_W-1:0] LINE_TDI = 6'h02;
    localparam logic [LINE_W-1:0] LINE_TDO = 6'h03;

    // slow clock output line
    localparam logic [LINE_W-1:0] LINE_SLOW_CLK = 6'h14;

    // two-wire lines: smbus group then plain group
    localparam int NUM_TWI = 6;
    localparam logic [LINE_W-1:0] TWI_LINES [NUM_TWI] = '{6'h15, 6'h1B, 6'h1C, 6'h05, 6'h07, 6'h11};

    // reset values
    localparam logic RST_PULL = 1'b0;
    localparam logic RST_TCK_PULL = 1'b1;
    localparam logic RST_RC_ON = 1'b1;
    localparam logic RST_FILT = 1'b1;

    // spike filter: time in ns, clock period in ps, cycles rounded up
    localparam int SPIKE_NS = 50;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SPIKE_CYCLES = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SPIKE_CNT_W = 4;
    localparam logic [SPIKE_CNT_W-1:0] SPIKE_LAST = SPIKE_CNT_W'(SPIKE_CYCLES - 1);
    localparam logic [SPIKE_CNT_W-1:0] SPIKE_ZERO = 4'h0;
    localparam logic [SPIKE_CNT_W-1:0] SPIKE_ONE = 4'h1;

    // test port decision state
    typedef enum logic [1:0] {ILR_TAP_IN_RESET, ILR_TAP_ON, ILR_TAP_OFF} ilr_tap_t;

endpackage : ilr_pkg

// *** src/ilr_spike_filter.sv ***
// input spike filter for a two-wire line
`timescale 1ns/1ps
module ilr_spike_filter (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic raw,
    output logic filt
);
    import ilr_pkg::*;

    logic [SPIKE_CNT_W-1:0] cnt; // cycles the raw level has differed
    logic [SPIKE_CNT_W-1:0] next_cnt;
    logic next_filt;

    // a new level passes only after it has held for the whole filter time
    always_comb begin
        next_cnt = SPIKE_ZERO;
        next_filt = filt;
        if (raw != filt) begin
            if (cnt == SPIKE_LAST) begin
                next_filt = raw;
            end else begin
                next_cnt = cnt + SPIKE_ONE;
            end
        end
    end

    // state registers, bus idles high
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt <= SPIKE_ZERO;
            filt <= RST_FILT;
        end else begin
            cnt <= next_cnt;
            filt <= next_filt;
        end
    end

endmodule : ilr_spike_filter

// *** src/ilr_rc_out_keeper.sv ***
// sticky enable of the slow rc clock output, restored only by power-up
`timescale 1ns/1ps
module ilr_rc_out_keeper (
    input wire logic sys_clk,
    input wire logic por_n,
    input wire logic drop,
    output logic on
);
    import ilr_pkg::*;

    logic next_on;

    // once dropped it stays off; nothing here can set it again
    always_comb begin
        next_on = on & ~drop;
    end

    // only power-on reset restores the enable
    always_ff @(posedge sys_clk) begin
        if (!por_n) begin
            on <= RST_RC_ON;
        end else begin
            on <= next_on;
        end
    end

endmodule : ilr_rc_out_keeper

// *** src/ilr_io_line_reset_config.sv ***
// io line reset defaults, test port enable and pin routing
// Notes on behaviour
// - test port on if test clock low at release
// - test port on: pull-ups tck/tms/tdi, tdo driven
// - tck pull-up forced on throughout reset
// - test port off: test pins serve gpio/peripherals
// - two-wire lines select two-wire function after reset
// - two-wire lines open-drain, inputs spike filtered
// - each line has its own pull-up enable
// - reset: inputs except slow clock line, pull-ups off except test clock line
// - reset: slow clock line selects function f
// - slow rc clock output runs during power-on reset
// - gpio or non-f function drops slow clock output
// - keep bit written zero drops slow clock output
// - dropped slow clock output stays off until power-up
// - crystal function does not drop rc output
`timescale 1ns/1ps
module ilr_io_line_reset_config (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic cfg_wr,
    input wire logic [ilr_pkg::LINE_W-1:0] cfg_line,
    input wire logic cfg_gpio,
    input wire logic [ilr_pkg::FN_W-1:0] cfg_fn,
    input wire logic cfg_pull,
    input wire logic keep_wr,
    input wire logic keep_wdata,
    input wire logic alt_xtal32_en,
    input wire logic slow_rc_osc,
    input wire logic tdo_data,
    input wire logic [ilr_pkg::NUM_LINES-1:0] gpio_out,
    input wire logic [ilr_pkg::NUM_LINES-1:0] gpio_oe,
    input wire logic [ilr_pkg::NUM_LINES-1:0] periph_out,
    input wire logic [ilr_pkg::NUM_LINES-1:0] periph_oe,
    input wire logic [ilr_pkg::NUM_LINES-1:0] pad_in,
    output logic [ilr_pkg::NUM_LINES-1:0] pad_out,
    output logic [ilr_pkg::NUM_LINES-1:0] pad_oe,
    output logic [ilr_pkg::NUM_LINES-1:0] pad_pull,
    output logic [ilr_pkg::NUM_LINES-1:0] line_in,
    output logic [ilr_pkg::NUM_LINES-1:0] line_gpio,
    output logic [ilr_pkg::NUM_LINES*ilr_pkg::FN_W-1:0] line_fn,
    output logic tap_enabled,
    output logic slow_rc_clock_output,
    output logic alt_xtal32_clean
);
    import ilr_pkg::*;

    // true for a two-wire capable line
    function automatic logic is_twi(input logic [LINE_W-1:0] idx);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < NUM_TWI; k++) begin
            if (TWI_LINES[k] == idx) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : is_twi

    // true for one of the four test port pins
    function automatic logic is_test(input logic [LINE_W-1:0] idx);
        return (idx == LINE_TCK) || (idx == LINE_TMS) || (idx == LINE_TDI) || (idx == LINE_TDO);
    endfunction : is_test

    // reset selection: gpio except two-wire and slow clock lines
    function automatic logic rst_gpio(input logic [LINE_W-1:0] idx);
        return !(is_twi(idx) || (idx == LINE_SLOW_CLK));
    endfunction : rst_gpio

    // reset function code per line
    function automatic logic [FN_W-1:0] rst_fn(input logic [LINE_W-1:0] idx);
        logic [FN_W-1:0] fn;
        fn = FN_A;
        if (is_twi(idx)) begin
            fn = FN_TWI;
        end else if (idx == LINE_SLOW_CLK) begin
            fn = FN_F;
        end
        return fn;
    endfunction : rst_fn

    // reset pull-up per line
    function automatic logic rst_pull(input logic [LINE_W-1:0] idx);
        return (idx == LINE_TCK) ? RST_TCK_PULL : RST_PULL;
    endfunction : rst_pull

    logic [NUM_LINES-1:0] gpio_sel; // 1 = line under gpio control
    logic [FN_W-1:0] fn_sel [NUM_LINES]; // peripheral function per line
    logic [NUM_LINES-1:0] pull_sw; // software pull-up enables
    logic [NUM_LINES-1:0] next_gpio_sel;
    logic [FN_W-1:0] next_fn_sel [NUM_LINES];
    logic [NUM_LINES-1:0] next_pull_sw;
    ilr_tap_t tap_state; // test port decision
    ilr_tap_t next_tap_state;
    logic rc_drop; // any cause that ends the slow clock output
    logic slow_rc_on; // sticky slow clock output enable
    logic [NUM_LINES-1:0] twi_active; // line currently serves two-wire
    logic [NUM_TWI-1:0] twi_filt; // filtered two-wire inputs

    // configuration writes, one line per strobe
    always_comb begin
        next_gpio_sel = gpio_sel;
        next_fn_sel = fn_sel;
        next_pull_sw = pull_sw;
        if (cfg_wr && (cfg_line < NUM_LINES)) begin
            next_gpio_sel[cfg_line] = cfg_gpio;
            next_fn_sel[cfg_line] = cfg_fn;
            next_pull_sw[cfg_line] = cfg_pull;
        end
    end

    // configuration registers with per-line reset defaults
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int k = 0; k < NUM_LINES; k++) begin
                gpio_sel[k] <= rst_gpio(LINE_W'(k));
                fn_sel[k] <= rst_fn(LINE_W'(k));
                pull_sw[k] <= rst_pull(LINE_W'(k));
            end
        end else begin
            gpio_sel <= next_gpio_sel;
            fn_sel <= next_fn_sel;
            pull_sw <= next_pull_sw;
        end
    end

    // test port decision taken in the first cycle after reset release
    always_comb begin
        next_tap_state = tap_state;
        unique case (tap_state)
            ILR_TAP_IN_RESET: begin
                // sample the test clock pin at release
                next_tap_state = pad_in[LINE_TCK] ? ILR_TAP_OFF : ILR_TAP_ON;
            end
            ILR_TAP_ON: begin
                next_tap_state = ILR_TAP_ON;
            end
            ILR_TAP_OFF: begin
                next_tap_state = ILR_TAP_OFF;
            end
        endcase
    end

    // decision register, cleared only by reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tap_state <= ILR_TAP_IN_RESET;
        end else begin
            tap_state <= next_tap_state;
        end
    end

    assign tap_enabled = (tap_state == ILR_TAP_ON);

    // drop causes; the crystal function is deliberately not one of them
    always_comb begin
        rc_drop = 1'b0;
        if (rst_n) begin
            if (gpio_sel[LINE_SLOW_CLK] || (fn_sel[LINE_SLOW_CLK] != FN_F)) begin
                rc_drop = 1'b1;
            end
            if (keep_wr && !keep_wdata) begin
                rc_drop = 1'b1;
            end
        end
    end

    // sticky enable, survives system reset, restored by power-up only
    ilr_rc_out_keeper u_keeper (
        .sys_clk(sys_clk),
        .por_n(por_n),
        .drop(rc_drop),
        .on(slow_rc_on)
    );

    assign slow_rc_clock_output = slow_rc_on;
    // the oscillator is undisturbed only once the rc output is gone
    assign alt_xtal32_clean = alt_xtal32_en & ~slow_rc_on;

    // per-line pad routing
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
            localparam logic [LINE_W-1:0] IDX = LINE_W'(gi);
            logic tap_owns; // test port has the pin

            assign tap_owns = tap_enabled && is_test(IDX);
            assign twi_active[gi] = is_twi(IDX) && !gpio_sel[gi] && (fn_sel[gi] == FN_TWI);
            assign line_gpio[gi] = gpio_sel[gi];
            assign line_fn[gi*FN_W +: FN_W] = fn_sel[gi];

            // driver selection by priority
            always_comb begin
                pad_out[gi] = 1'b0;
                pad_oe[gi] = 1'b0;
                if ((IDX == LINE_SLOW_CLK) && slow_rc_on) begin
                    // slow clock runs even while the device is held in reset
                    pad_out[gi] = slow_rc_osc;
                    pad_oe[gi] = 1'b1;
                end else if (!rst_n) begin
                    // every other line is an input in reset
                    pad_oe[gi] = 1'b0;
                end else if (tap_owns) begin
                    // tdo is a driven output, other test pins are inputs
                    pad_out[gi] = (IDX == LINE_TDO) ? tdo_data : 1'b0;
                    pad_oe[gi] = (IDX == LINE_TDO);
                end else if (twi_active[gi]) begin
                    // open-drain: enable only while pulling low
                    pad_out[gi] = 1'b0;
                    pad_oe[gi] = periph_oe[gi] & ~periph_out[gi];
                end else if (gpio_sel[gi]) begin
                    pad_out[gi] = gpio_out[gi];
                    pad_oe[gi] = gpio_oe[gi];
                end else begin
                    pad_out[gi] = periph_out[gi];
                    pad_oe[gi] = periph_oe[gi];
                end
            end

            // pull-up selection
            always_comb begin
                if (tap_owns) begin
                    pad_pull[gi] = (IDX != LINE_TDO);
                end else if ((IDX == LINE_TCK) && (!rst_n || (tap_state == ILR_TAP_IN_RESET))) begin
                    pad_pull[gi] = 1'b1;
                end else begin
                    pad_pull[gi] = pull_sw[gi];
                end
            end
        end
    endgenerate

    // spike filters on the two-wire lines
    generate
        for (gi = 0; gi < NUM_TWI; gi++) begin : g_twi
            ilr_spike_filter u_filt (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .raw(pad_in[TWI_LINES[gi]]),
                .filt(twi_filt[gi])
            );
        end
    endgenerate

    // inputs to the controllers, filtered where two-wire is active
    always_comb begin
        line_in = pad_in;
        for (int k = 0; k < NUM_TWI; k++) begin
            if (twi_active[TWI_LINES[k]]) begin
                line_in[TWI_LINES[k]] = twi_filt[k];
            end
        end
    end

    // helper views for the checks below
    logic [NUM_LINES-1:0] oe_but_slow;
    logic [NUM_LINES-1:0] pull_but_tck;
    logic [NUM_LINES-1:0] twi_mask;
    always_comb begin
        oe_but_slow = pad_oe;
        oe_but_slow[LINE_SLOW_CLK] = 1'b0;
        pull_but_tck = pad_pull;
        pull_but_tck[LINE_TCK] = 1'b0;
        twi_mask = '0;
        for (int k = 0; k < NUM_TWI; k++) begin
            twi_mask[TWI_LINES[k]] = 1'b1;
        end
    end

    sequence s_reset_held;
        !rst_n ##1 !rst_n;
    endsequence

    sequence s_release_low;
        (tap_state == ILR_TAP_IN_RESET) && !pad_in[LINE_TCK];
    endsequence

    a_tap_capture_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_release_low |=> tap_enabled [*3]) else $error("test port not enabled after low tck");

    a_tap_capture_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tap_state == ILR_TAP_IN_RESET) && pad_in[LINE_TCK] |=> !tap_enabled) else $error("test port enabled with high tck");

    a_tap_decision_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tap_state != ILR_TAP_IN_RESET) |=> $stable(tap_state)) else $error("test port decision changed");

    a_tap_pin_pulls: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tap_enabled |-> pad_pull[LINE_TCK] && pad_pull[LINE_TMS] && pad_pull[LINE_TDI]
        && !pad_pull[LINE_TDO] && pad_oe[LINE_TDO] && (pad_out[LINE_TDO] == tdo_data)) else $error("test pin pulls wrong");

    a_tap_off_gpio: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tap_state == ILR_TAP_OFF) && line_gpio[LINE_TMS] |-> pad_oe[LINE_TMS] == gpio_oe[LINE_TMS])
        else $error("test pin not released to gpio");

    a_tck_reset_pull: assert property (@(posedge sys_clk) disable iff (!por_n)
        s_reset_held |-> pad_pull[LINE_TCK]) else $error("tck pull-up off in reset");

    a_reset_line_state: assert property (@(posedge sys_clk) disable iff (!por_n)
        s_reset_held |-> (oe_but_slow == '0) && (pull_but_tck == '0)) else $error("line not input without pull in reset");

    a_reset_functions: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> ((line_gpio & twi_mask) == '0) && !line_gpio[LINE_SLOW_CLK]
        && (fn_sel[LINE_SLOW_CLK] == FN_F) && (fn_sel[TWI_LINES[0]] == FN_TWI)) else $error("reset functions wrong");

    a_pull_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_wr && (cfg_line < NUM_LINES) |=> pull_sw[$past(cfg_line)] == $past(cfg_pull)) else $error("pull-up write lost");

    a_rc_por_out: assert property (@(posedge sys_clk)
        !por_n |=> pad_oe[LINE_SLOW_CLK] && (pad_out[LINE_SLOW_CLK] == slow_rc_osc))
        else $error("slow clock absent in power-on reset");

    a_rc_drop_fn: assert property (@(posedge sys_clk) disable iff (!por_n)
        rst_n && (line_gpio[LINE_SLOW_CLK] || (fn_sel[LINE_SLOW_CLK] != FN_F)) |=> !slow_rc_clock_output)
        else $error("slow clock kept off function f");

    a_rc_drop_keep: assert property (@(posedge sys_clk) disable iff (!por_n)
        rst_n && keep_wr && !keep_wdata |=> !slow_rc_clock_output) else $error("slow clock kept after keep cleared");

    a_rc_sticky_off: assert property (@(posedge sys_clk) disable iff (!por_n)
        !slow_rc_clock_output |=> !slow_rc_clock_output [*2]) else $error("slow clock output came back");

    // antecedent built from the documented causes, not from the drop net itself
    a_rc_xtal_keep: assert property (@(posedge sys_clk) disable iff (!por_n)
        alt_xtal32_en && slow_rc_on && !(rst_n && (line_gpio[LINE_SLOW_CLK] || (fn_sel[LINE_SLOW_CLK] != FN_F)))
        && !(rst_n && keep_wr && !keep_wdata) |=> slow_rc_on) else $error("crystal function cleared rc output");

    for (gi = 0; gi < NUM_TWI; gi++) begin : g_twi_chk
        a_twi_open_drain: assert property (@(posedge sys_clk) disable iff (!rst_n)
            twi_active[TWI_LINES[gi]] && !tap_enabled |-> !pad_out[TWI_LINES[gi]]
            && (pad_oe[TWI_LINES[gi]] == (periph_oe[TWI_LINES[gi]] & ~periph_out[TWI_LINES[gi]])))
            else $error("two-wire line not open-drain");
    end

endmodule : ilr_io_line_reset_config

// *** tb/ilr_board_model.sv ***
// board side of the io lines: resistors, two-wire devices and test-port debugger
`timescale 1ns/1ps
module ilr_board_model (
    input wire logic sys_clk,
    input wire logic [ilr_pkg::NUM_LINES-1:0] pad_out,
    input wire logic [ilr_pkg::NUM_LINES-1:0] pad_oe,
    input wire logic [ilr_pkg::NUM_LINES-1:0] pad_pull,
    input wire logic [ilr_pkg::NUM_LINES-1:0] ext_en,
    input wire logic [ilr_pkg::NUM_LINES-1:0] ext_val,
    input wire logic [ilr_pkg::NUM_LINES-1:0] board_pull,
    output logic [ilr_pkg::NUM_LINES-1:0] pad_in
);
    import ilr_pkg::*;
    logic [NUM_LINES-1:0] float_pat = '0; // undriven lines wander each cycle
    // a floating line must not look like a stable level
    always @(posedge sys_clk) begin
        float_pat <= ~float_pat;
    end
    // wired-and of device and board drivers, then resistors, else floating
    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            if (pad_oe[i] || ext_en[i]) begin
                pad_in[i] = (pad_oe[i] ? pad_out[i] : 1'b1) & (ext_en[i] ? ext_val[i] : 1'b1);
            end else if (pad_pull[i] || board_pull[i]) begin
                pad_in[i] = 1'b1;
            end else begin
                pad_in[i] = float_pat[i];
            end
        end
    end
endmodule : ilr_board_model

// *** tb/tb.sv ***
// self-checking bench for the io line reset and configuration block
`timescale 1ns/1ps
module tb;
    import ilr_pkg::*;
    logic sys_clk = 1'b0;
    logic slow_rc_osc = 1'b0; // stand-in for the slow oscillator
    logic tdo_data = 1'b0; // debugger data toggles with it
    logic rst_n, por_n, cfg_wr, cfg_gpio, cfg_pull, keep_wr, keep_wdata, alt_xtal32_en;
    logic [LINE_W-1:0] cfg_line;
    logic [FN_W-1:0] cfg_fn;
    logic [NUM_LINES-1:0] gpio_out, gpio_oe, periph_out, periph_oe, pad_in, ext_en, ext_val, board_pull;
    logic [NUM_LINES-1:0] pad_out, pad_oe, pad_pull, line_in, line_gpio;
    logic [NUM_LINES*FN_W-1:0] line_fn;
    logic tap_enabled, slow_rc_clock_output, alt_xtal32_clean;
    int miscompares = 0;
    int n_tests = 0;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    // free-running slow clock and test data
    always @(posedge sys_clk) begin
        slow_rc_osc <= ~slow_rc_osc;
        tdo_data <= slow_rc_osc;
    end

    ilr_io_line_reset_config u_ilr_io_line_reset_config (
        .sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .cfg_wr(cfg_wr), .cfg_line(cfg_line),
        .cfg_gpio(cfg_gpio), .cfg_fn(cfg_fn), .cfg_pull(cfg_pull), .keep_wr(keep_wr),
        .keep_wdata(keep_wdata), .alt_xtal32_en(alt_xtal32_en), .slow_rc_osc(slow_rc_osc),
        .tdo_data(tdo_data), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .periph_out(periph_out),
        .periph_oe(periph_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull(pad_pull),
        .line_in(line_in), .line_gpio(line_gpio), .line_fn(line_fn), .tap_enabled(tap_enabled),
        .slow_rc_clock_output(slow_rc_clock_output), .alt_xtal32_clean(alt_xtal32_clean)
    );

    ilr_board_model u_ilr_board_model (
        .sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull(pad_pull),
        .ext_en(ext_en), .ext_val(ext_val), .board_pull(board_pull), .pad_in(pad_in)
    );

    // compare and count, four-state exact
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    // wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // one line configuration write
    task automatic cfg(input logic [LINE_W-1:0] ln, input logic g, input logic [FN_W-1:0] f, input logic p);
        @(posedge sys_clk);
        cfg_wr <= 1'b1;
        cfg_line <= ln;
        cfg_gpio <= g;
        cfg_fn <= f;
        cfg_pull <= p;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
        #1;
    endtask : cfg

    // power manager keep bit write
    task automatic keep(input logic v);
        @(posedge sys_clk);
        keep_wr <= 1'b1;
        keep_wdata <= v;
        @(posedge sys_clk);
        keep_wr <= 1'b0;
        #1;
    endtask : keep

    // enter reset and leave it held, optionally with power-on reset for 4 cycles
    task automatic hold_reset(input logic por);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        por_n <= ~por;
        repeat (4) @(posedge sys_clk);
        por_n <= 1'b1;
        tick(1);
    endtask : hold_reset

    // leave reset; tap decision taken on the first edge after
    task automatic release_reset;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(2);
    endtask : release_reset

    // defaults seen while reset holds, drive requests forced on
    task automatic t_defaults;
        logic [NUM_LINES-1:0] exp_gpio;
        logic [NUM_LINES*FN_W-1:0] exp_fn;
        gpio_oe <= '1;
        hold_reset(1'b1);
        exp_gpio = '1;
        exp_fn = '0;
        for (int i = 0; i < NUM_TWI; i++) exp_gpio[TWI_LINES[i]] = 1'b0;
        exp_gpio[LINE_SLOW_CLK] = 1'b0;
        exp_fn[LINE_SLOW_CLK*FN_W +: FN_W] = FN_F;
        chk(line_gpio, exp_gpio);
        chk(line_fn, exp_fn);
        chk(pad_pull, 36'h000000001);
        chk(pad_oe, 36'h000100000);
        chk(slow_rc_clock_output, 1'b1);
        chk(pad_out[LINE_SLOW_CLK], slow_rc_osc);
        @(posedge sys_clk);
        gpio_oe <= '0;
        release_reset;
        $display("test defaults done");
    endtask : t_defaults

    // debugger holds the test clock low across release
    task automatic t_tap_on;
        @(posedge sys_clk);
        ext_en[0] <= 1'b1;
        ext_val[0] <= 1'b0;
        hold_reset(1'b0);
        release_reset;
        chk(tap_enabled, 1'b1);
        chk(pad_pull[3:0], 4'h7);
        chk(pad_oe[3], 1'b1);
        chk(pad_out[3], tdo_data);
        ext_val[0] <= 1'b1;
        cfg(LINE_TMS, 1'b0, FN_A, 1'b0);
        tick(3);
        chk(tap_enabled, 1'b1);
        chk(pad_pull[1], 1'b1);
        ext_en[0] <= 1'b0;
        $display("test tap on done");
    endtask : t_tap_on

    // test clock pulled high at release: test pins become ordinary lines
    task automatic t_tap_off;
        hold_reset(1'b0);
        release_reset;
        chk(tap_enabled, 1'b0);
        cfg(LINE_TDO, 1'b1, FN_A, 1'b0);
        gpio_oe[3] <= 1'b1;
        gpio_out[3] <= 1'b1;
        cfg(LINE_TMS, 1'b0, FN_F, 1'b1);
        periph_oe[1] <= 1'b1;
        periph_out[1] <= 1'b0;
        tick(1);
        chk({pad_oe[3], pad_out[3]}, 2'h3);
        chk({pad_oe[1], pad_out[1], pad_pull[1]}, 3'h5);
        gpio_oe[3] <= 1'b0;
        periph_oe[1] <= 1'b0;
        $display("test tap off done");
    endtask : t_tap_off

    // independent pull-ups, out-of-range index ignored
    task automatic t_pulls;
        cfg(6'h08, 1'b1, FN_A, 1'b1);
        cfg(6'h1E, 1'b1, FN_A, 1'b1);
        chk({pad_pull[30], pad_pull[9], pad_pull[8]}, 3'h5);
        cfg(6'h28, 1'b1, FN_A, 1'b0);
        chk(pad_pull[8], 1'b1);
        cfg(6'h08, 1'b1, FN_A, 1'b0);
        chk({pad_pull[30], pad_pull[8]}, 2'h2);
        $display("test pulls done");
    endtask : t_pulls

    // two-wire line: open-drain drive and spike filter
    task automatic t_twi;
        @(posedge sys_clk);
        periph_oe[5] <= 1'b1;
        periph_out[5] <= 1'b1;
        tick(1);
        chk(pad_oe[5], 1'b0);
        periph_out[5] <= 1'b0;
        tick(1);
        chk({pad_oe[5], pad_out[5]}, 2'h2);
        periph_oe[5] <= 1'b0;
        ext_en[5] <= 1'b1;
        ext_val[5] <= 1'b0;
        tick(5);
        ext_en[5] <= 1'b0;
        tick(12);
        chk(line_in[5], 1'b1);
        ext_en[5] <= 1'b1;
        tick(9);
        chk(line_in[5], 1'b1);
        tick(1);
        chk(line_in[5], 1'b0);
        ext_en[5] <= 1'b0;
        tick(12);
        chk(line_in[5], 1'b1);
        $display("test two-wire done");
    endtask : t_twi

    // slow clock output: each drop cause, no re-enable before power-up
    task automatic t_slow;
        for (int c = 0; c < 3; c++) begin
            hold_reset(1'b1);
            release_reset;
            chk(slow_rc_clock_output, 1'b1);
            alt_xtal32_en <= 1'b1;
            tick(2);
            chk({slow_rc_clock_output, alt_xtal32_clean}, 2'h2);
            alt_xtal32_en <= 1'b0;
            keep(1'b1);
            chk(slow_rc_clock_output, 1'b1);
            case (c)
                0: keep(1'b0);
                1: cfg(LINE_SLOW_CLK, 1'b1, FN_F, 1'b0);
                default: cfg(LINE_SLOW_CLK, 1'b0, FN_A, 1'b0);
            endcase
            tick(1); // a cause written into the line config acts one edge after the write lands
            chk({slow_rc_clock_output, pad_oe[20]}, 2'h0);
            cfg(LINE_SLOW_CLK, 1'b0, FN_F, 1'b0);
            hold_reset(1'b0);
            release_reset;
            chk(slow_rc_clock_output, 1'b0);
            alt_xtal32_en <= 1'b1;
            tick(1);
            chk(alt_xtal32_clean, 1'b1);
            alt_xtal32_en <= 1'b0;
        end
        $display("test slow clock done");
    endtask : t_slow

    // verdict and end of run
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // main sequence, inputs given values at time zero
    initial begin
        {rst_n, por_n, cfg_wr, cfg_gpio, cfg_pull, keep_wr, keep_wdata, alt_xtal32_en} = '0;
        cfg_line = '0;
        cfg_fn = '0;
        {gpio_out, gpio_oe, periph_out, periph_oe, ext_en, ext_val, board_pull} = '0;
        for (int i = 0; i < NUM_TWI; i++) board_pull[TWI_LINES[i]] = 1'b1;
        t_defaults;
        t_tap_on;
        t_tap_off;
        t_pulls;
        t_twi;
        t_slow;
        stop_test;
    end

    // watchdog: the run needs well under a thousand cycles
    initial begin
        #20000;
        miscompares++;
        $display("watchdog expired");
        stop_test;
    end
endmodule : tb
